// [ssb_pkg.sv]
// shared types and constants for the burst sram pin control block
// assumes one rising-edge clock; the device itself has no reset pin
package ssb_pkg;
  localparam int ADDR_W = 20;
  localparam int LANES = 4;
  localparam int LANE_DQ_W = 8;
  localparam int LANE_W = LANE_DQ_W + 1;
  localparam int DQ_W = LANES * LANE_DQ_W;
  localparam int WORD_W = LANES * LANE_W;
  localparam int BURST_W = 2;
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  localparam logic [DQ_W-1:0] DQ_RST = 32'h00000000;
  localparam logic [LANES-1:0] LANE_RST = 4'h0;
  // strap reads high when floating, so interleaved is the safe default
  localparam logic INTERLEAVE_RST = 1'b1;
  localparam logic SYNC_HIGH_RST = 1'b1;

  typedef enum logic [1:0] {
    SSB_OP_DESEL = 2'b00,
    SSB_OP_READ = 2'b01,
    SSB_OP_WRITE = 2'b10
  } ssb_op_t;

  // one command as sampled at a clock edge
  typedef struct packed {
    logic sel;
    logic wr;
    logic ld;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] bwN;
  } ssb_cmd_t;
endpackage

// [ssb_burst_ctr.sv]
// two-bit burst counter with linear or interleaved order
// assumes load and advance are already qualified by the caller
module ssb_burst_ctr import ssb_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // control
  input wire logic load,
  input wire logic advance,
  input wire logic interleave,
  input wire logic [BURST_W-1:0] seed,
  // next offset in the burst
  output logic [BURST_W-1:0] offNext
);
  logic [BURST_W-1:0] seed_q;
  logic [BURST_W-1:0] count_q;
  logic [BURST_W-1:0] countNext;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      seed_q <= BURST_CNT_RST;
      count_q <= BURST_CNT_RST;
    end else if (load) begin
      seed_q <= seed;
      count_q <= BURST_CNT_RST;
    end else if (advance) begin
      count_q <= countNext;
    end
  end

  // wraps inside the four-word group of the loaded address
  assign countNext = count_q + BURST_STEP;
  assign offNext = interleave ? (seed_q ^ countNext) : (seed_q + countNext);
endmodule

// [ssb_sram_ctrl.sv]
// synchronous flow-through burst sram: pin control, burst and array
// assumes the controller drives synchronous pins on sys_clk; the output
// enable, sleep and strap pins are asynchronous and are synchronised here
// Notes on behaviour
// - advance high at a qualified edge steps the burst counter
// - advance low at a qualified edge loads the address pins
// - inputs are taken on rising edges only while the qualifier is low
// - selected only when both low selects are low and the high one high
// - output enable low lets data pins drive, high floats them
// - outputs float in write data phase, after emerging, and deselected
// - qualifier high freezes state without deselecting
// - sleep request keeps data and stops activity; controller holds it low
// - write data on the data lines is latched at the rising edge
// - a read returns the word at that cycle's address
// - parity lines act like data lines, gated by their byte selects
// - strap low picks linear order, high or open picks interleaved
// - the two low address bits seed the burst counter
// - byte selects sampled with the strobe choose written lanes
// - read starts with selects active, strobe high and advance low
module ssb_sram_ctrl import ssb_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // synchronous control pins
  input wire logic [ADDR_W-1:0] addr,
  input wire logic advanceOrLoad,
  input wire logic clockQualifyN,
  input wire logic chipSelectLowA,
  input wire logic chipSelectHigh,
  input wire logic chipSelectLowB,
  input wire logic writeEnableN,
  input wire logic [LANES-1:0] byteWriteSelectN,
  // asynchronous pins
  input wire logic outputEnableN,
  input wire logic sleepRequest,
  input wire logic burstMode,
  // data lines
  input wire logic [DQ_W-1:0] dqIn,
  output logic [DQ_W-1:0] dqOut,
  output logic dqOe,
  // parity lines
  input wire logic [LANES-1:0] parityDataLinesIn,
  output logic [LANES-1:0] parityDataLinesOut,
  output logic parityDataLinesOe
);
  logic [WORD_W-1:0] mem [0:DEPTH-1];

  logic oeMeta_q, oeN_q, slpMeta_q, sleep_q, strapMeta_q, interleave_q;
  ssb_cmd_t cmd;
  logic qual, load, adv, desel_q, emerge_q;
  ssb_op_t op_q, opNow;
  logic [ADDR_W-1:0] curAddr_q, accAddr;
  logic [BURST_W-1:0] offNext;
  logic wrPend_q;
  logic [ADDR_W-1:0] wrAddr_q;
  logic [LANES-1:0] wrLane_q;
  logic [WORD_W-1:0] wrWord, memRd, rdWord;
  logic readPhase_q;
  logic writePhase;

  function automatic logic [WORD_W-1:0] pack_word(input logic [DQ_W-1:0] d,
                                                  input logic [LANES-1:0] p);
    logic [WORD_W-1:0] w;
    w = '0;
    for (int i = 0; i < LANES; i++) begin
      w[i*LANE_W +: LANE_W] = {p[i], d[i*LANE_DQ_W +: LANE_DQ_W]};
    end
    return w;
  endfunction

  // asynchronous pins: first flop feeds only the second
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      oeMeta_q <= SYNC_HIGH_RST;
      oeN_q <= SYNC_HIGH_RST;
    end else begin
      oeMeta_q <= outputEnableN;
      oeN_q <= oeMeta_q;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      slpMeta_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      slpMeta_q <= sleepRequest;
      sleep_q <= slpMeta_q;
    end
  end

  // strap is caught after reset release, never loaded under reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      strapMeta_q <= INTERLEAVE_RST;
      interleave_q <= INTERLEAVE_RST;
    end else begin
      strapMeta_q <= burstMode;
      interleave_q <= strapMeta_q;
    end
  end

  // command decode
  assign cmd.sel = !chipSelectLowA && chipSelectHigh && !chipSelectLowB;
  assign cmd.wr = !writeEnableN;
  assign cmd.ld = !advanceOrLoad;
  assign cmd.addr = addr;
  assign cmd.bwN = byteWriteSelectN;

  // sleep blocks edges as well as the qualifier does
  assign qual = !clockQualifyN && !sleep_q;
  assign load = qual && cmd.sel && cmd.ld;
  // advance continues the running burst; after deselect it is not honoured
  assign adv = qual && cmd.sel && !cmd.ld && !desel_q;

  always_comb begin
    opNow = SSB_OP_DESEL;
    if (load) begin
      opNow = cmd.wr ? SSB_OP_WRITE : SSB_OP_READ;
    end else if (adv) begin
      opNow = op_q;
    end
  end

  ssb_burst_ctr u_ctr (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .load(load),
    .advance(adv),
    .interleave(interleave_q),
    .seed(cmd.addr[BURST_W-1:0]),
    .offNext(offNext)
  );

  assign accAddr = load ? cmd.addr : {curAddr_q[ADDR_W-1:BURST_W], offNext};

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      curAddr_q <= ADDR_RST;
    end else if (load || adv) begin
      curAddr_q <= accAddr;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_q <= SSB_OP_DESEL;
      desel_q <= 1'b1;
      emerge_q <= 1'b0;
    end else if (qual) begin
      op_q <= opNow;
      desel_q <= !cmd.sel;
      // advancing straight out of deselect has no valid address
      emerge_q <= desel_q && cmd.sel && !cmd.ld;
    end
  end

  // write data follows its address by one qualified edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= ADDR_RST;
      wrLane_q <= LANE_RST;
    end else if (qual) begin
      wrPend_q <= opNow == SSB_OP_WRITE;
      wrAddr_q <= accAddr;
      wrLane_q <= ~cmd.bwN;
    end
  end

  assign writePhase = wrPend_q;
  assign wrWord = pack_word(dqIn, parityDataLinesIn);
  assign memRd = mem[accAddr];

  // one process owns the array, so it keeps a single writer
  // lane memory writes, parity bit rides with its byte
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (qual && wrPend_q && wrLane_q[i]) begin
        mem[wrAddr_q][i*LANE_W +: LANE_W] <= wrWord[i*LANE_W +: LANE_W];
      end
    end
  end

  // forward a write landing at the same edge so a read sees new data
  always_comb begin
    rdWord = memRd;
    for (int i = 0; i < LANES; i++) begin
      if (wrPend_q && wrLane_q[i] && wrAddr_q == accAddr) begin
        rdWord[i*LANE_W +: LANE_W] = wrWord[i*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      readPhase_q <= 1'b0;
    end else if (qual) begin
      readPhase_q <= opNow == SSB_OP_READ;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dqOut <= DQ_RST;
      parityDataLinesOut <= LANE_RST;
    end else if (qual && opNow == SSB_OP_READ) begin
      for (int i = 0; i < LANES; i++) begin
        dqOut[i*LANE_DQ_W +: LANE_DQ_W] <= rdWord[i*LANE_W +: LANE_DQ_W];
        parityDataLinesOut[i] <= rdWord[i*LANE_W + LANE_DQ_W];
      end
    end
  end

  // outputs are masked by hardware before the enable pin is considered
  assign dqOe = readPhase_q && !writePhase && !emerge_q && !desel_q && !sleep_q
                && !oeN_q;
  assign parityDataLinesOe = dqOe;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence ldEdge;
    load;
  endsequence

  sequence advEdge;
    adv;
  endsequence

  adv_keeps_group_a: assert property (adv |=> curAddr_q[ADDR_W-1:BURST_W] ==
      $past(curAddr_q[ADDR_W-1:BURST_W]))
    else $error("advance changed the address group");

  load_takes_addr_a: assert property (load |=> curAddr_q == $past(addr))
    else $error("load did not take the address pins");

  cen_freezes_state_a: assert property (clockQualifyN |=> $stable(curAddr_q)
      && $stable(op_q) && $stable(desel_q) && $stable(dqOut))
    else $error("state moved while the qualifier was high");

  desel_floats_a: assert property (qual && !cmd.sel |=> desel_q && !dqOe)
    else $error("device drove after a deselect edge");

  write_phase_mask_a: assert property (writePhase |-> !dqOe && !parityDataLinesOe)
    else $error("outputs driven during write data phase");

  oe_pin_float_a: assert property (outputEnableN [*3] |-> !dqOe)
    else $error("outputs driven with the enable pin high");

  read_returns_word_a: assert property (load && !cmd.wr && !wrPend_q |=>
      dqOut[LANE_DQ_W-1:0] == $past(memRd[LANE_DQ_W-1:0]))
    else $error("read data does not match the array");

  lane_write_a: assert property (qual && wrPend_q && wrLane_q[0] |=>
      mem[$past(wrAddr_q)][LANE_W-1:0] == $past({parityDataLinesIn[0], dqIn[7:0]}))
    else $error("lane zero write not stored");

  lane_skip_a: assert property (qual && wrPend_q && !wrLane_q[0] && $past(1'b1) |=>
      mem[$past(wrAddr_q)][LANE_W-1:0] == $past(mem[wrAddr_q][LANE_W-1:0]))
    else $error("disabled lane was written");

  burst_wrap_a: assert property (ldEdge ##1 advEdge [*4] |=>
      curAddr_q == $past(curAddr_q, 4))
    else $error("burst did not wrap after four steps");

  burst_order_a: assert property (ldEdge ##1 advEdge |=> curAddr_q[1:0] ==
      (interleave_q ? ($past(curAddr_q[1:0]) ^ 2'h1) : ($past(curAddr_q[1:0]) + 2'h1)))
    else $error("burst step does not follow the strap order");

  sleep_float_a: assert property (sleep_q |-> !dqOe ##1 $stable(curAddr_q))
    else $error("activity during sleep");

  // command-level checks: what each taken edge leaves behind
  read_start_a: assert property (load && !cmd.wr |=> readPhase_q && !writePhase)
    else $error("read command did not open a read phase");

  write_mask_a: assert property (load && cmd.wr |=>
      writePhase && !dqOe && !parityDataLinesOe)
    else $error("write command left the outputs driven");

  lane_select_a: assert property (load && cmd.wr |=>
      wrLane_q == ~$past(byteWriteSelectN))
    else $error("write lanes differ from the byte selects");

  read_parity_a: assert property (load && !cmd.wr && !wrPend_q |=>
      parityDataLinesOut[0] == $past(memRd[LANE_DQ_W]))
    else $error("read parity does not match the array");

  emerge_mask_a: assert property (qual && desel_q && cmd.sel && !cmd.ld |=> !dqOe &&
      $stable(curAddr_q))
    else $error("advance out of deselect was honoured");

  oe_drive_a: assert property (load && !cmd.wr ##1 (!oeN_q && !sleep_q) |-> dqOe)
    else $error("read not driven with the enable low");

  sleep_hold_a: assert property (sleep_q |=> $stable(op_q) && $stable(wrPend_q)
      && $stable(dqOut))
    else $error("state moved during sleep");

  burst_group_a: assert property (ldEdge ##1 advEdge |=>
      curAddr_q[ADDR_W-1:BURST_W] == $past(addr[ADDR_W-1:BURST_W], 2))
    else $error("burst left the loaded address group");
endmodule

// [ssb_ctl_model.sv]
// memory controller model that drives every pin of the burst sram except clock and reset
// assumes the bench calls its tasks; pins change only at falling edges
module ssb_ctl_model import ssb_pkg::*; (
  // clock
  input wire logic sys_clk,
  // command pins
  output logic [ADDR_W-1:0] addr,
  output logic advanceOrLoad,
  output logic clockQualifyN,
  output logic chipSelectLowA,
  output logic chipSelectHigh,
  output logic chipSelectLowB,
  output logic writeEnableN,
  output logic [LANES-1:0] byteWriteSelectN,
  // static pins
  output logic outputEnableN,
  output logic sleepRequest,
  output logic burstMode,
  // write data
  output logic [DQ_W-1:0] dqIn,
  output logic [LANES-1:0] parityDataLinesIn
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {chipSelectLowA, chipSelectHigh, chipSelectLowB} = 3'h5;
    advanceOrLoad = 1'b0;
    clockQualifyN = 1'b0;
    writeEnableN = 1'b1;
    byteWriteSelectN = 4'hf;
    addr = '0;
    {outputEnableN, sleepRequest, burstMode} = 3'h1;
    {parityDataLinesIn, dqIn} = '0;
  end

  // one qualified edge; idle data toggles so a stale word never matches
  task automatic cyc(input logic [2:0] cs, input logic ld, wr, input logic [ADDR_W-1:0] a,
      input logic [LANES-1:0] bw, input logic dv, input logic [WORD_W-1:0] w);
    @(negedge sys_clk);
    {chipSelectLowA, chipSelectHigh, chipSelectLowB} = cs;
    advanceOrLoad = ld;
    writeEnableN = ~wr;
    byteWriteSelectN = bw;
    addr = a;
    {parityDataLinesIn, dqIn} = dv ? w : ~{parityDataLinesIn, dqIn};
    @(posedge sys_clk);
    #1;
  endtask

  // suspend with a deselect on the pins that must not be taken
  task automatic hold(input int n);
    logic [2:0] keep;
    keep = {chipSelectLowA, chipSelectHigh, chipSelectLowB};
    @(negedge sys_clk);
    clockQualifyN = 1'b1;
    {chipSelectLowA, chipSelectHigh, chipSelectLowB} = 3'h5;
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
    clockQualifyN = 1'b0;
    {chipSelectLowA, chipSelectHigh, chipSelectLowB} = keep;
  endtask

  task automatic pins(input logic oeN, slp, mode);
    @(negedge sys_clk);
    {outputEnableN, sleepRequest, burstMode} = {oeN, slp, mode};
  endtask
endmodule

// [tb.sv]
// self-checking bench for the burst sram pin control block
// assumes the controller model drives every pin except clock and reset
module tb import ssb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic LO = 1'b0;
  localparam logic HI = 1'b1;
  localparam logic [2:0] SEL = 3'h2;
  localparam logic [2:0] DES = 3'h5;
  localparam logic [ADDR_W-1:0] ADR = 20'h00010;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic advanceOrLoad, clockQualifyN, chipSelectLowA, chipSelectHigh, chipSelectLowB;
  logic writeEnableN, outputEnableN, sleepRequest, burstMode, dqOe, parityDataLinesOe;
  logic [LANES-1:0] byteWriteSelectN, parityDataLinesIn, parityDataLinesOut;
  logic [DQ_W-1:0] dqIn, dqOut;
  wire logic [WORD_W-1:0] rdWord = {parityDataLinesOut, dqOut};
  logic [WORD_W-1:0] mem [int];
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;

  ssb_sram_ctrl ssb_sram_ctrl_i (.sys_clk, .arst_n, .addr, .advanceOrLoad, .clockQualifyN,
    .chipSelectLowA, .chipSelectHigh, .chipSelectLowB, .writeEnableN, .byteWriteSelectN,
    .outputEnableN, .sleepRequest, .burstMode, .dqIn, .dqOut, .dqOe, .parityDataLinesIn,
    .parityDataLinesOut, .parityDataLinesOe);
  ssb_ctl_model ctl (.sys_clk, .addr, .advanceOrLoad, .clockQualifyN, .chipSelectLowA,
    .chipSelectHigh, .chipSelectLowB, .writeEnableN, .byteWriteSelectN, .outputEnableN,
    .sleepRequest, .burstMode, .dqIn, .parityDataLinesIn);

  always #2.5 sys_clk = ~sys_clk;

  task automatic check(input string what, input logic [WORD_W-1:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // data and parity enables must always agree
  task automatic chkOe(input logic e);
    check("output enables", WORD_W'({parityDataLinesOe, dqOe}), WORD_W'({e, e}));
  endtask

  task automatic put(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] bw,
      input logic [WORD_W-1:0] w);
    logic [WORD_W-1:0] o;
    o = mem.exists(int'(a)) ? mem[int'(a)] : '0;
    for (int i = 0; i < LANES; i++) begin
      if (!bw[i]) begin
        o[8*i +: 8] = w[8*i +: 8];
        o[DQ_W + i] = w[DQ_W + i];
      end
    end
    mem[int'(a)] = o;
  endtask

  task automatic t_write_read();
    ctl.cyc(SEL, LO, HI, ADR, 4'h0, LO, '0);
    chkOe(LO);
    ctl.cyc(SEL, LO, LO, ADR, 4'hf, HI, 36'h9a5a51234);
    put(ADR, 4'h0, 36'h9a5a51234);
    chkOe(HI);
    check("read word", rdWord, mem[int'(ADR)]);
    $display("write_read done");
  endtask

  task automatic t_lanes();
    ctl.cyc(SEL, LO, HI, ADR, 4'h0, HI, '0);
    ctl.cyc(SEL, LO, HI, ADR, 4'h5, HI, 36'h123456789);
    put(ADR, 4'h0, 36'h123456789);
    ctl.cyc(SEL, LO, LO, ADR, 4'hf, HI, 36'hfedcba987);
    put(ADR, 4'h5, 36'hfedcba987);
    check("lane merge", rdWord, mem[int'(ADR)]);
    $display("lanes done");
  endtask

  task automatic t_burst(input logic m);
    logic [1:0] off;
    ctl.pins(LO, LO, m);
    repeat (3) ctl.cyc(DES, LO, LO, ADR, 4'hf, LO, '0);
    for (int k = 0; k < 5; k++) begin
      ctl.cyc(k < 4 ? SEL : DES, LO ^ (k > 0 && k < 4), HI, 20'h00106, 4'h0, k > 0,
        WORD_W'(k * 17 + m));
      off = m ? 2'(2 ^ (k - 1)) : 2'(1 + k);
      if (k > 0) put(20'h00104 + 20'(off), 4'h0, WORD_W'(k * 17 + m));
    end
    // fifth read wraps back to the seed word
    for (int k = 0; k < 5; k++) begin
      ctl.cyc(SEL, k > 0, LO, 20'h00105, 4'hf, LO, '0);
      off = m ? 2'(1 ^ k) : 2'(1 + k);
      check("burst word", rdWord, mem[int'(20'h00104 + 20'(off))]);
    end
    $display("burst done");
  endtask

  task automatic t_suspend();
    ctl.cyc(SEL, LO, LO, ADR, 4'hf, LO, '0);
    ctl.hold(3);
    chkOe(HI);
    check("held word", rdWord, mem[int'(ADR)]);
    $display("suspend done");
  endtask

  task automatic t_select();
    for (int c = 0; c < 8; c++) begin
      ctl.cyc(3'(c), LO, LO, ADR, 4'hf, LO, '0);
      chkOe(c == 2);
    end
    // advance straight out of deselect is refused and masked
    ctl.cyc(SEL, HI, LO, ADR, 4'hf, LO, '0);
    chkOe(LO);
    $display("select done");
  endtask

  task automatic t_oe_sleep();
    ctl.pins(HI, LO, HI);
    repeat (3) ctl.cyc(SEL, LO, LO, ADR, 4'hf, LO, '0);
    chkOe(LO);
    ctl.pins(LO, HI, HI);
    repeat (3) ctl.cyc(DES, LO, LO, ADR, 4'hf, LO, '0);
    ctl.cyc(SEL, LO, HI, ADR, 4'h0, LO, '0);
    ctl.cyc(DES, LO, LO, ADR, 4'hf, HI, '0);
    ctl.pins(LO, LO, HI);
    repeat (3) ctl.cyc(DES, LO, LO, ADR, 4'hf, LO, '0);
    ctl.cyc(SEL, LO, LO, ADR, 4'hf, LO, '0);
    check("word kept in sleep", rdWord, mem[int'(ADR)]);
    $display("oe_sleep done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    t_write_read();
    t_lanes();
    t_burst(LO);
    t_burst(HI);
    t_suspend();
    t_select();
    t_oe_sleep();
    tally_and_finish();
  end
endmodule
